//--- logic/scmc_fast_div.sv
// fast clock divider producing a tick at fast/1 down to fast/64
`timescale 1ns/10ps
module scmc_fast_div (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       fast_tick,  // one tick per fast clock period
  input  wire logic       hl_sel,     // undivided fast clock
  input  wire logic [2:0] div_sel,    // divider code
  output logic            div_tick    // divided tick, registered
);
  import scmc_pkg::*;

  logic [5:0] cnt_r;   // free running fast period counter
  logic       tick_r;  // registered output
  wire  [5:0] mask;    // low counter bits that must be all ones
  wire        hit;     // counter at end of divided period

  // code 010 keeps six bits (/64), code 111 keeps one bit (/2)
  assign mask = 6'h3F >> (div_sel - DIV_CODE_MIN);
  assign hit  = (cnt_r & mask) == mask;
  assign div_tick = tick_r;

  // count fast periods; the counter runs on across a divider change, so the first period after it may be short
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= 6'h00;
      tick_r <= 1'b0;
    end else begin
      if (fast_tick) cnt_r <= cnt_r + 6'h01;
      tick_r <= fast_tick & (hl_sel | hit);
    end
  end

endmodule : scmc_fast_div

//--- logic/scmc_glitch_free_mux.sv
// glitch free selection between the divided fast tick and the sub tick
`timescale 1ns/10ps
module scmc_glitch_free_mux (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic req_sub,    // wanted source: 1 sub, 0 fast
  input  wire logic fast_tick,  // divided fast tick
  input  wire logic sub_tick,   // sub clock tick
  output logic      out_tick,   // selected tick, registered
  output logic      on_sub      // source in use, registered
);
  import scmc_pkg::*;

  logic cur_sub_r;  // source now driving the output
  logic out_r;      // registered output tick
  wire  switching;  // request differs from source in use
  wire  new_tick;   // tick of requested source
  wire  cur_tick;   // tick of source in use

  assign switching = req_sub != cur_sub_r;
  assign new_tick  = req_sub ? sub_tick : fast_tick;
  assign cur_tick  = cur_sub_r ? sub_tick : fast_tick;
  assign out_tick  = out_r;
  assign on_sub    = cur_sub_r;

  // while switching only the requested source's tick passes, so no period is cut short
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur_sub_r <= 1'b0;
      out_r     <= 1'b0;
    end else begin
      out_r <= switching ? new_tick : cur_tick;
      if (switching && new_tick) cur_sub_r <= req_sub;
    end
  end

endmodule : scmc_glitch_free_mux

//--- logic/scmc_pkg.sv
// shared constants, types and helpers of the system clock mode control block
package scmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register bus geometry
  localparam int unsigned ADDR_W = 4;  // register address width
  localparam int unsigned DATA_W = 8;  // register data width

  // register offsets
  localparam logic [ADDR_W-1:0] MODE_REG_OFS     = 4'h0;  // clock_mode_reg
  localparam logic [ADDR_W-1:0] TIMEBASE_REG_OFS = 4'h1;  // timebase_control_reg
  localparam logic [ADDR_W-1:0] CTRL_REG_OFS     = 4'h2;  // idle core clock control
  localparam logic [ADDR_W-1:0] STATUS_REG_OFS   = 4'h3;  // operating mode readback

  ////////////////////////////////////////////////////////////////////////////
  // clock_mode_reg fields
  localparam int unsigned MODE_DIV_MSB       = 7;  // clock_divider_select msb
  localparam int unsigned MODE_DIV_LSB       = 5;  // clock_divider_select lsb
  localparam int unsigned MODE_FAST_WAKE_BIT = 4;  // fast wake-up enable
  localparam int unsigned MODE_SLOW_RDY_BIT  = 3;  // slow_osc_ready_flag, read only
  localparam int unsigned MODE_FAST_RDY_BIT  = 2;  // fast oscillator ready, read only
  localparam int unsigned MODE_IDLE_EN_BIT   = 1;  // halt goes to idle instead of sleep
  localparam int unsigned MODE_HL_BIT        = 0;  // high_low_clock_select
  localparam logic [DATA_W-1:0] MODE_REG_RST = 8'h03;

  // timebase_control_reg fields
  localparam int unsigned TIMEBASE_LP_BIT        = 0;  // slow_crystal_power_select
  localparam logic [DATA_W-1:0] TIMEBASE_REG_RST = 8'h00;

  // control register fields
  localparam int unsigned CTRL_CORE_ON_BIT   = 7;  // core clock kept running in idle
  localparam logic [DATA_W-1:0] CTRL_REG_RST = 8'h00;

  // status register fields
  localparam int unsigned STATUS_ON_SUB_BIT = 7;  // core clock currently taken from sub clock

  ////////////////////////////////////////////////////////////////////////////
  // divider codes that pick the sub clock, and the lowest fast code
  localparam logic [2:0] DIV_CODE_SUB0 = 3'h0;
  localparam logic [2:0] DIV_CODE_SUB1 = 3'h1;
  localparam logic [2:0] DIV_CODE_MIN  = 3'h2;  // fast clock divided by 64

  // oscillator ready counts, in cycles of the oscillator itself
  localparam int unsigned RDY_W = 11;
  localparam logic [RDY_W-1:0] SLOW_XTAL_READY_CYC = 11'd1024;
  localparam logic [RDY_W-1:0] SLOW_RC_READY_CYC   = 11'd2;
  localparam logic [RDY_W-1:0] FAST_XTAL_READY_CYC = 11'd1024;
  localparam logic [RDY_W-1:0] FAST_RC_READY_CYC   = 11'd16;

  ////////////////////////////////////////////////////////////////////////////
  // operating modes, one-hot
  typedef enum logic [5:0] {
    OP_NORMAL = 6'h01,
    OP_SLOW   = 6'h02,
    OP_IDLE_CORE_CLOCK_OFF  = 6'h04,
    OP_IDLE_CORE_CLOCK_ON  = 6'h08,
    OP_DEEP_SLEEP_MODE = 6'h10,
    OP_SLEEP_WITH_SUB_CLOCK = 6'h20
  } scmc_op_e;

  // one register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } scmc_bus_req_s;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic core;  // core_clock tick
    logic sub;   // sub_clock tick
    logic wdt;   // watchdog_base_clock tick
  } scmc_clk_en_s;

  // true when the selection fields pick the sub clock as core clock
  function automatic logic scmc_sel_is_sub(input logic hl, input logic [2:0] div);
    return !hl && (div == DIV_CODE_SUB0 || div == DIV_CODE_SUB1);
  endfunction : scmc_sel_is_sub

endpackage : scmc_pkg

//--- logic/scmc_top.sv
// system clock source selection and operating mode control
//
// What this block does
// - one bit picks quick start or low power
// - power select bit clears at power-on
// - crystal keeps running in either power mode
// - unused slow crystal frees its pins
// - slow crystal awaited after power-up before use
// - core clock from fast or sub clock
// - fast clock from crystal or rc option
// - sub clock from crystal or rc option
// - fast clock divided by one to sixty-four
// - sub clock feeds peripherals and wake-up
// - switching to sub stops fast oscillator
// - six modes; normal and slow run cpu
// - four halted modes gate clocks per mode
// - slow mode uses slow source, fast off
// - sleep, or idle with core clock off, stops core clock
// - divider codes map sub and fast divisions
// - high select bit gives undivided fast clock
// - slow ready after 1024 or 2 cycles
`timescale 1ns/10ps
module scmc_top (
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  wire scmc_pkg::scmc_bus_req_s  bus_req,                 // register request
  output logic [scmc_pkg::DATA_W-1:0]   rdata,                   // read data, cycle after read
  input  wire logic                     halt_req,                // cpu halt, one cycle
  input  wire logic                     wake_req,                // wake-up event, one cycle
  input  wire logic                     cfg_fast_src_rc,         // fast source option: 1 rc
  input  wire logic                     cfg_slow_src_rc,         // sub source option: 1 rc
  input  wire logic                     cfg_wdt_from_sub,        // watchdog clocked from sub
  input  wire logic                     keep_sub_in_sleep,       // a user needs sub in sleep
  input  wire logic                     slow_crystal_osc_in,     // slow crystal output, async
  input  wire logic                     slow_rc_osc_in,          // slow rc output, async
  output scmc_pkg::scmc_clk_en_s        clk_en,                  // clock enables
  output logic                          cpu_run,                 // cpu may execute
  output scmc_pkg::scmc_op_e            op_mode,                 // current operating mode
  output logic                          fast_osc_enable,         // fast oscillator on
  output logic                          slow_crystal_osc_enable, // slow crystal on
  output logic                          slow_rc_osc_enable,      // slow rc on
  output logic                          slow_crystal_low_power,  // crystal low power mode
  output logic                          slow_crystal_pins_gpio   // crystal pins free as io
);
  import scmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [2:0]        div_sel_r;     // clock_divider_select
  logic              fast_wake_r;   // fast wake-up enable
  logic              idle_en_r;     // halt enters idle
  logic              hl_sel_r;      // high_low_clock_select
  logic              lp_sel_r;      // slow_crystal_power_select
  logic              core_on_r;     // core clock stays on in idle
  logic [DATA_W-1:0] rdata_r;       // read data register

  ////////////////////////////////////////////////////////////////////////////
  // oscillator and mode state

  logic [1:0]        osc_sync1_r;   // first synchroniser stage, read by stage two only
  logic [1:0]        osc_sync2_r;   // second synchroniser stage
  logic              sub_prev_r;    // previous selected sub level for edge detect
  logic [RDY_W-1:0]  slow_cnt_r;    // slow oscillator start-up counter
  logic [RDY_W-1:0]  fast_cnt_r;    // fast oscillator start-up counter
  logic              fast_en_r;     // fast oscillator enable
  logic              xtal_en_r;     // slow crystal enable
  logic              rc_en_r;       // slow rc enable
  logic              pins_gpio_r;   // crystal pins released
  logic              cpu_run_r;     // cpu running
  scmc_op_e          mode_r;        // operating mode
  scmc_op_e          mode_nxt;      // next operating mode
  scmc_clk_en_s      clk_en_r;      // registered enables

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire sel_sub;        // selection picks the sub clock
  wire run_mode;       // cpu executing
  wire sub_raw;        // rising edge of selected sub oscillator
  wire sub_sel_level;  // synchronised selected sub level
  wire slow_rdy;       // slow_osc_ready_flag
  wire fast_rdy;       // fast oscillator stable
  wire [RDY_W-1:0] slow_lim;  // slow ready count for the chosen source
  wire [RDY_W-1:0] fast_lim;  // fast ready count for the chosen source
  wire fast_tick;      // one per fast period while usable
  wire sub_tick;       // usable sub tick
  wire div_tick;       // divided fast tick
  wire mux_tick;       // glitch free core source tick
  wire on_sub;         // core source is sub now
  wire req_sub;        // core source wanted
  wire core_gate;      // mode lets the core clock run
  wire sub_gate;       // mode lets the sub clock run
  wire wdt_gate;       // mode lets the watchdog clock run
  wire wr_mode;        // write to clock_mode_reg
  wire wr_tb;          // write to timebase_control_reg
  wire wr_ctrl;        // write to control register
  wire [DATA_W-1:0] rd_mux;  // read data selection
  wire [DATA_W-1:0] mode_rd; // clock_mode_reg as read
  wire fast_en_nxt;    // next fast oscillator enable

  assign sel_sub   = scmc_sel_is_sub(hl_sel_r, div_sel_r);
  assign run_mode  = (mode_r == OP_NORMAL) || (mode_r == OP_SLOW);

  // synchronised selected source; an edge is one sub period
  assign sub_sel_level = cfg_slow_src_rc ? osc_sync2_r[1] : osc_sync2_r[0];
  assign sub_raw       = sub_sel_level & ~sub_prev_r;

  // ready counts depend on which oscillator is fitted
  assign slow_lim = cfg_slow_src_rc ? SLOW_RC_READY_CYC : SLOW_XTAL_READY_CYC;
  assign fast_lim = cfg_fast_src_rc ? FAST_RC_READY_CYC : FAST_XTAL_READY_CYC;
  assign slow_rdy = slow_cnt_r == slow_lim;
  assign fast_rdy = fast_cnt_r == fast_lim;

  // the fast source runs at the system rate once it is stable
  assign fast_tick = fast_en_r & fast_rdy;
  // the sub clock is only handed on once the slow oscillator is stable
  assign sub_tick  = sub_raw & slow_rdy & (mode_r != OP_DEEP_SLEEP_MODE);

  // fast wake-up: run from sub while the fast oscillator settles
  assign req_sub = sel_sub | (fast_wake_r & ~fast_rdy & slow_rdy);

  // per mode gating of the three clocks
  assign core_gate = run_mode || (mode_r == OP_IDLE_CORE_CLOCK_ON);
  assign sub_gate  = (mode_r != OP_DEEP_SLEEP_MODE);
  assign wdt_gate  = (mode_r == OP_IDLE_CORE_CLOCK_OFF) ? cfg_wdt_from_sub : sub_gate;

  // the fast oscillator stops whenever the selection picks the sub clock or the core halts without it
  assign fast_en_nxt = !sel_sub && ((mode_nxt == OP_NORMAL) || (mode_nxt == OP_IDLE_CORE_CLOCK_ON));

  // register decode
  assign wr_mode = bus_req.wr && (bus_req.addr == MODE_REG_OFS);
  assign wr_tb   = bus_req.wr && (bus_req.addr == TIMEBASE_REG_OFS);
  assign wr_ctrl = bus_req.wr && (bus_req.addr == CTRL_REG_OFS);

  assign mode_rd = {div_sel_r, fast_wake_r, slow_rdy, fast_rdy, idle_en_r, hl_sel_r};

  // unmapped addresses read as zero
  assign rd_mux = (bus_req.addr == MODE_REG_OFS)     ? mode_rd :
                  (bus_req.addr == TIMEBASE_REG_OFS) ? {{(DATA_W-1){1'b0}}, lp_sel_r} :
                  (bus_req.addr == CTRL_REG_OFS)     ? {core_on_r, {(DATA_W-1){1'b0}}} :
                  (bus_req.addr == STATUS_REG_OFS)   ? {on_sub, 1'b0, mode_r} :
                  {DATA_W{1'b0}};

  assign rdata                   = rdata_r;
  assign clk_en                  = clk_en_r;
  assign cpu_run                 = cpu_run_r;
  assign op_mode                 = mode_r;
  assign fast_osc_enable         = fast_en_r;
  assign slow_crystal_osc_enable = xtal_en_r;
  assign slow_rc_osc_enable      = rc_en_r;
  assign slow_crystal_low_power  = lp_sel_r;
  assign slow_crystal_pins_gpio  = pins_gpio_r;

  ////////////////////////////////////////////////////////////////////////////
  // next operating mode

  // halt is only honoured while running, wake only while halted
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      OP_NORMAL, OP_SLOW: begin
        if (halt_req) begin
          if (idle_en_r) mode_nxt = core_on_r ? OP_IDLE_CORE_CLOCK_ON : OP_IDLE_CORE_CLOCK_OFF;
          else mode_nxt = keep_sub_in_sleep ? OP_SLEEP_WITH_SUB_CLOCK : OP_DEEP_SLEEP_MODE;
        end else begin
          mode_nxt = sel_sub ? OP_SLOW : OP_NORMAL;
        end
      end
      OP_IDLE_CORE_CLOCK_OFF, OP_IDLE_CORE_CLOCK_ON, OP_DEEP_SLEEP_MODE, OP_SLEEP_WITH_SUB_CLOCK: begin
        if (wake_req) mode_nxt = sel_sub ? OP_SLOW : OP_NORMAL;
      end
      default: begin
        mode_nxt = OP_NORMAL;  // illegal code recovers to normal
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes and read data

  // read only ready bits ignore writes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_sel_r   <= MODE_REG_RST[MODE_DIV_MSB:MODE_DIV_LSB];
      fast_wake_r <= MODE_REG_RST[MODE_FAST_WAKE_BIT];
      idle_en_r   <= MODE_REG_RST[MODE_IDLE_EN_BIT];
      hl_sel_r    <= MODE_REG_RST[MODE_HL_BIT];
    end else if (wr_mode) begin
      div_sel_r   <= bus_req.wdata[MODE_DIV_MSB:MODE_DIV_LSB];
      fast_wake_r <= bus_req.wdata[MODE_FAST_WAKE_BIT];
      idle_en_r   <= bus_req.wdata[MODE_IDLE_EN_BIT];
      hl_sel_r    <= bus_req.wdata[MODE_HL_BIT];
    end
  end

  // power select comes up in quick start; the oscillator never stops for it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lp_sel_r  <= TIMEBASE_REG_RST[TIMEBASE_LP_BIT];
      core_on_r <= CTRL_REG_RST[CTRL_CORE_ON_BIT];
    end else begin
      if (wr_tb) lp_sel_r <= bus_req.wdata[TIMEBASE_LP_BIT];
      if (wr_ctrl) core_on_r <= bus_req.wdata[CTRL_CORE_ON_BIT];
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rdata_r <= {DATA_W{1'b0}};
    else rdata_r <= bus_req.rd ? rd_mux : {DATA_W{1'b0}};
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator input synchronisers

  // both oscillator outputs are asynchronous to clk_sys
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      osc_sync1_r <= 2'h0;
      osc_sync2_r <= 2'h0;
      sub_prev_r  <= 1'b0;
    end else begin
      osc_sync1_r <= {slow_rc_osc_in, slow_crystal_osc_in};
      osc_sync2_r <= osc_sync1_r;
      sub_prev_r  <= sub_sel_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator start-up counters

  // slow count restarts in deep sleep, so the flag drops and is re-earned on wake
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) slow_cnt_r <= {RDY_W{1'b0}};
    else if (mode_r == OP_DEEP_SLEEP_MODE) slow_cnt_r <= {RDY_W{1'b0}};
    else if (sub_raw && !slow_rdy) slow_cnt_r <= slow_cnt_r + 11'd1;
  end

  // fast count restarts each time the fast oscillator is turned off
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) fast_cnt_r <= {RDY_W{1'b0}};
    else if (!fast_en_r) fast_cnt_r <= {RDY_W{1'b0}};
    else if (!fast_rdy) fast_cnt_r <= fast_cnt_r + 11'd1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode and oscillator enables

  // sub oscillator stays on in every mode except deep sleep
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_r      <= OP_NORMAL;
      cpu_run_r   <= 1'b0;
      fast_en_r   <= 1'b0;
      xtal_en_r   <= 1'b0;
      rc_en_r     <= 1'b0;
      pins_gpio_r <= 1'b0;
    end else begin
      mode_r      <= mode_nxt;
      cpu_run_r   <= (mode_nxt == OP_NORMAL) || (mode_nxt == OP_SLOW);
      fast_en_r   <= fast_en_nxt;
      xtal_en_r   <= !cfg_slow_src_rc && (mode_nxt != OP_DEEP_SLEEP_MODE);
      rc_en_r     <= cfg_slow_src_rc && (mode_nxt != OP_DEEP_SLEEP_MODE);
      pins_gpio_r <= cfg_slow_src_rc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock generation

  scmc_fast_div u_div (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .fast_tick (fast_tick),
    .hl_sel    (hl_sel_r),
    .div_sel   (div_sel_r),
    .div_tick  (div_tick)
  );

  scmc_glitch_free_mux u_mux (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .req_sub   (req_sub),
    .fast_tick (div_tick),
    .sub_tick  (sub_tick),
    .out_tick  (mux_tick),
    .on_sub    (on_sub)
  );

  // final gating; watchdog follows sub or the core tick per option
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk_en_r <= '0;
    end else begin
      clk_en_r.core <= mux_tick & core_gate;
      clk_en_r.sub  <= sub_tick & sub_gate;
      clk_en_r.wdt  <= (cfg_wdt_from_sub ? sub_tick : mux_tick) & wdt_gate &
                       (cfg_wdt_from_sub | core_gate);
    end
  end

endmodule : scmc_top

//--- sim/scmc_top_assertions.sv
// concurrent checks at the ports of the clock mode control block
`timescale 1ns/10ps
module scmc_top_assertions (
  input wire logic                   clk_sys,
  input wire logic                   nrst,
  input wire scmc_pkg::scmc_bus_req_s bus_req,
  input wire logic [scmc_pkg::DATA_W-1:0] rdata,
  input wire logic                   halt_req,
  input wire scmc_pkg::scmc_clk_en_s clk_en,
  input wire logic                   cpu_run,
  input wire scmc_pkg::scmc_op_e     op_mode,
  input wire logic                   fast_osc_enable,
  input wire logic                   slow_crystal_osc_enable,
  input wire logic                   slow_crystal_low_power,
  input wire logic                   slow_crystal_pins_gpio
);
  import scmc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the source selection, so checks need no view inside
  logic hl_r;   // undivided fast clock picked
  logic sub_r;  // sub clock picked
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hl_r  <= 1'b1;
      sub_r <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == MODE_REG_OFS) begin
      hl_r  <= bus_req.wdata[MODE_HL_BIT];
      sub_r <= !bus_req.wdata[MODE_HL_BIT] && bus_req.wdata[MODE_DIV_MSB:MODE_DIV_LSB] < DIV_CODE_MIN;
    end
  end
  // five settled cycles leave the tick pipeline free of older selections
  sequence s_fast_run;
    (hl_r && op_mode == OP_NORMAL) [*5];
  endsequence
  sequence s_halted;
    (op_mode inside {OP_IDLE_CORE_CLOCK_OFF, OP_DEEP_SLEEP_MODE, OP_SLEEP_WITH_SUB_CLOCK}) [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_LP_WRITE: assert property (bus_req.wr && bus_req.addr == TIMEBASE_REG_OFS
    |=> slow_crystal_low_power == $past(bus_req.wdata[TIMEBASE_LP_BIT])) else $error("power select missed a write");
  AST_LP_READ: assert property (bus_req.rd && bus_req.addr == TIMEBASE_REG_OFS
    |=> rdata[TIMEBASE_LP_BIT] == slow_crystal_low_power) else $error("power select readback differs");
  AST_PINS: assert property (slow_crystal_osc_enable |-> !slow_crystal_pins_gpio)
    else $error("crystal pins released while crystal runs");
  AST_RUN: assert property ($past(nrst) |-> cpu_run == (op_mode inside {OP_NORMAL, OP_SLOW}))
    else $error("cpu run flag disagrees with mode");
  AST_HALT: assert property (halt_req && cpu_run |-> ##[1:2] !cpu_run)
    else $error("halt did not stop the cpu");
  AST_DEEP_SLEEP_MODE: assert property ((op_mode == OP_DEEP_SLEEP_MODE) [*4] |-> clk_en == 3'h0)
    else $error("clock enable pulse in deep sleep");
  AST_CORE_OFF: assert property (s_halted |-> !clk_en.core)
    else $error("core tick while halted");
  AST_HL_EVERY: assert property (s_fast_run ##0 clk_en.core |=> clk_en.core)
    else $error("undivided fast clock skipped a cycle");
  AST_SUB_FAST_OFF: assert property ($rose(sub_r) |-> ##[1:150] !fast_osc_enable)
    else $error("fast oscillator kept on with sub clock");
endmodule : scmc_top_assertions

bind scmc_top scmc_top_assertions u_chk (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
  .halt_req(halt_req), .clk_en(clk_en), .cpu_run(cpu_run), .op_mode(op_mode), .fast_osc_enable(fast_osc_enable),
  .slow_crystal_osc_enable(slow_crystal_osc_enable), .slow_crystal_low_power(slow_crystal_low_power),
  .slow_crystal_pins_gpio(slow_crystal_pins_gpio));

//--- sim/testbench.sv
// self-checking bench of the clock mode control block
`timescale 1ns/10ps
module testbench;
  import scmc_pkg::*;
  logic clk_sys, nrst, halt_req, wake_req, keep_sub, xo, cpu_run, fen, xen, ren, lp, pg;
  scmc_bus_req_s     req;
  logic [DATA_W-1:0] rdata;
  scmc_clk_en_s      clk_en;
  scmc_op_e          op_mode;
  int err_total, checks, ph, xedges, nc, ns;
  int m_reg [4];                                 // register model
  logic [7:0] rnd, got;
  logic [7:0] msk [4] = '{8'hF3, 8'h01, 8'h80, 8'h00};
  scmc_op_e hmode [4] = '{OP_IDLE_CORE_CLOCK_OFF, OP_IDLE_CORE_CLOCK_ON, OP_SLEEP_WITH_SUB_CLOCK, OP_DEEP_SLEEP_MODE};
  scmc_top dut (.clk_sys(clk_sys), .nrst(nrst), .bus_req(req), .rdata(rdata), .halt_req(halt_req),
    .wake_req(wake_req), .cfg_fast_src_rc(1'b0), .cfg_slow_src_rc(1'b0), .cfg_wdt_from_sub(1'b1),
    .keep_sub_in_sleep(keep_sub), .slow_crystal_osc_in(xo), .slow_rc_osc_in(~xo), .clk_en(clk_en),
    .cpu_run(cpu_run), .op_mode(op_mode), .fast_osc_enable(fen), .slow_crystal_osc_enable(xen),
    .slow_rc_osc_enable(ren), .slow_crystal_low_power(lp), .slow_crystal_pins_gpio(pg));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // slow oscillator stand-in, six system cycles a period, rising edges counted
  always @(posedge clk_sys) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (ph == 2) xo <= ~xo;
    xedges <= !nrst ? 0 : xedges + int'(ph == 2 && !xo);
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask : cmp8
  // window edges may cut one tick either way
  task automatic cmpn(input int g, input int e);
    checks++;
    if (g < e - 1 || g > e + 1) begin
      err_total++;
      $display("[FAIL] %0t count %0d expected %0d", $time, g, e);
    end
  endtask : cmpn
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
    if (a < 4'h3) m_reg[a] = d & msk[a];
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 got = rdata;
  endtask : rd
  // ready bits and unkept bits are masked; unmapped places read zero
  task automatic rd_chk(input logic [3:0] a);
    rd(a);
    // status reads back normal mode on the fast source until the sub clock is picked
    cmp8(got & (a < 4'h3 ? msk[a] : 8'hFF), a < 4'h3 ? 8'(m_reg[a]) : (a == 4'h3 ? 8'h01 : 8'h00));
  endtask : rd_chk
  task automatic count(input int n);
    nc = 0;
    ns = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 nc += int'(clk_en.core === 1'b1);
      ns += int'(clk_en.sub === 1'b1);
    end
  endtask : count
  task automatic finish_test;
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // the slow oscillator start-up dominates, some ten thousand cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, halt_req, wake_req, keep_sub, xo, ph, err_total, checks} = '0;
    req = '0;
    rnd = 8'h33;
    m_reg = '{3, 0, 0, 0};
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1 cmp8({4'h0, pg, xen, ren, lp}, 8'h04);
    for (int a = 0; a < 6; a++) rd_chk(4'(a));
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(TIMEBASE_REG_OFS, rnd);
      #1 cmp8({7'h00, lp}, rnd & 8'h01);
      rd_chk(TIMEBASE_REG_OFS);
      wr(4'h5, rnd);
      rd_chk(4'h5);
    end
    wait (xedges == 1000);
    rd(MODE_REG_OFS);
    cmp8(got & 8'h08, 8'h00);
    wait (xedges == 1030);
    rd(MODE_REG_OFS);
    cmp8(got & 8'h0C, 8'h0C);
    count(20);
    cmpn(nc, 20);
    // every divider code, hl cleared and idle enable kept
    for (int c = 7; c >= 0; c--) begin
      wr(MODE_REG_OFS, {3'(c), 5'h02});
      count(120);
      count(384);
      cmpn(nc, c > 1 ? 384 >> (8 - c) : 64);
    end
    cmp8({7'h00, fen}, 8'h00);
    rd(STATUS_REG_OFS);
    cmp8(got & 8'h80, 8'h80);
    // each halted mode in turn, deep sleep last as it resets the slow start-up
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_REG_OFS, {i == 1, 7'h00});
      wr(MODE_REG_OFS, {6'h00, i < 2, 1'b0});
      keep_sub <= (i == 2);
      halt_req <= 1'b1;
      @(posedge clk_sys);
      halt_req <= 1'b0;
      count(60);
      cmp8({2'h0, op_mode}, {2'h0, hmode[i]});
      cmpn(nc, i == 1 ? 10 : 0);
      cmpn(ns, i == 3 ? 0 : 10);
      wake_req <= 1'b1;
      @(posedge clk_sys);
      wake_req <= 1'b0;
      count(4);
      cmp8({2'h0, op_mode}, {2'h0, OP_SLOW});
    end
    finish_test();
  end
endmodule : testbench
